// >>> hdl/realtime_counter_prescaler.sv
// Free-running 8-bit event counter with shared prescaler and overflow interrupt.
// Assumes the core drives option bits, strobes and sleep on clk_sys;
// count_pin is asynchronous.
//
// Notes on behaviour
// - Source select 1 counts count-pin pulses, 0 counts instruction cycles.
// - On the pin, edge select 0 takes rising edges and 1 takes falling edges.
// - The one prescaler serves either the counter or the watchdog, never both.
// - Serving the counter, the prescaler takes each event and the counter steps on its tap bit.
// - The counter is 8 bits and wraps from maximum to zero; divide by 256 spans 65536 events.
// - A wrap from ffh to 00h requests an interrupt only while the mask bit is 0; one during service, except in the return cycle, is dropped.
// - The mask bit and the alias option work only when the option fuse was cleared.
// - During sleep the counter stops; its value is not to be trusted after wakeup.
// - A counter write clears the prescaler while the prescaler serves the counter.
// - At most one pin event counts per instruction cycle; extra edges merge.
// - With the pending flag present, bit 7 of timer-1 control B sets on each wrap.
// - An accepted interrupt jumps to 0000h and a return resumes the interrupted code.
// - The counter is readable and writable so software can preload a start value.
`timescale 1ns/100ps
module realtime_counter_prescaler #(
  parameter logic [3:0] INSTR_DIV = event_counter_pkg::INSTR_DIV_DEFAULT,
  parameter bit HAS_PENDING_FLAG = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // External count pin
  input wire logic count_pin,
  // Option bits
  input wire logic source_select,
  input wire logic edge_polarity_sel,
  input wire logic prescaler_assign,
  input wire logic [2:0] divide_select,
  input wire logic overflow_irq_mask,
  input wire logic w_alias_select,
  input wire logic option_fuse_n,
  // Counter register access
  input wire logic counter_wr,
  input wire logic [event_counter_pkg::CNT_W-1:0] counter_wdata,
  output logic [event_counter_pkg::CNT_W-1:0] rt_event_counter,
  // Timer-1 control B pending bit
  input wire logic timer1_control_b_wr,
  input wire logic [7:0] timer1_control_b_wdata,
  output logic overflow_pending,
  // Watchdog side
  input wire logic watchdog_rollover,
  input wire logic watchdog_clear,
  output logic watchdog_reset,
  // Core interrupt handshake and power
  input wire logic sleep_mode,
  input wire logic irq_accept,
  input wire logic irq_return,
  input wire logic irq_return_load_w,
  output logic irq_request,
  output logic irq_in_service,
  output logic [11:0] irq_vector,
  output logic w_alias_active
);
  import event_counter_pkg::*;

  logic [3:0] div_cnt_reg;
  logic instr_tick_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  logic pin_edge;
  logic event_seen_reg;
  logic count_event;
  logic pre_advance;
  logic pre_clear;
  logic pre_counter_carry;
  logic pre_watchdog_carry;
  logic [PRE_W-1:0] pre_count;
  logic counter_step;
  logic wrap;
  logic options_live;
  logic irq_enabled;
  svc_state_t svc_reg;
  svc_state_t svc_next;

  // Instruction cycle enable; held off in sleep since the core clock stops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg <= 4'h0;
      instr_tick_reg <= 1'b0;
    end else if (sleep_mode) begin
      instr_tick_reg <= 1'b0;
    end else if (div_cnt_reg >= INSTR_DIV - 4'h1) begin
      div_cnt_reg <= 4'h0;
      instr_tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
      instr_tick_reg <= 1'b0;
    end
  end

  // Pin synchroniser; only the second and third stages feed logic
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= count_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_edge = (edge_polarity_sel == EDGE_RISE) ?
    (pin_sync_reg & ~pin_prev_reg) : (~pin_sync_reg & pin_prev_reg);

  // Edges latch until the next instruction cycle; an edge in the consuming
  // cycle stays latched so it is never lost
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      event_seen_reg <= 1'b0;
    end else if (pin_edge) begin
      event_seen_reg <= 1'b1;
    end else if (instr_tick_reg) begin
      event_seen_reg <= 1'b0;
    end
  end

  assign count_event = instr_tick_reg & ~sleep_mode &
    ((source_select == SRC_PIN) ? event_seen_reg : 1'b1);

  // Prescaler owner routing
  assign pre_advance = (prescaler_assign == PRE_TO_COUNTER) ?
    count_event : watchdog_rollover;
  assign pre_clear = (counter_wr && prescaler_assign == PRE_TO_COUNTER) ||
    (watchdog_clear && prescaler_assign == PRE_TO_WATCHDOG);

  shared_prescaler #(
    .W(PRE_W)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(pre_clear),
    .advance(pre_advance),
    .divide_select(divide_select),
    .count_reg(pre_count),
    .counter_carry(pre_counter_carry),
    .watchdog_carry(pre_watchdog_carry)
  );

  assign counter_step = (prescaler_assign == PRE_TO_COUNTER) ?
    pre_counter_carry : count_event;
  assign wrap = counter_step && !counter_wr && rt_event_counter == CNT_MAX;

  // Counter; a software write beats a step in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rt_event_counter <= CNT_RESET;
    end else if (counter_wr) begin
      rt_event_counter <= counter_wdata;
    end else if (counter_step) begin
      rt_event_counter <= rt_event_counter + 8'h01;
    end
  end

  // Watchdog reset: prescaler carry while the prescaler serves it, raw rollover otherwise
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      watchdog_reset <= 1'b0;
    end else if (prescaler_assign == PRE_TO_WATCHDOG) begin
      watchdog_reset <= pre_watchdog_carry;
    end else begin
      watchdog_reset <= watchdog_rollover;
    end
  end

  // Option fuse gates the mask and alias bits; fuse set leaves irq off
  assign options_live = ~option_fuse_n;
  assign irq_enabled = options_live & ~overflow_irq_mask;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      w_alias_active <= 1'b0;
    end else begin
      w_alias_active <= options_live & w_alias_select;
    end
  end

  // Pending flag: set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      overflow_pending <= 1'b0;
    end else if (!HAS_PENDING_FLAG) begin
      overflow_pending <= 1'b0;
    end else if (wrap) begin
      overflow_pending <= 1'b1;
    end else if (timer1_control_b_wr && !timer1_control_b_wdata[PEND_BIT]) begin
      overflow_pending <= 1'b0;
    end
  end

  // Interrupt service sequence: single level, no nesting
  always_comb begin
    svc_next = svc_reg;
    case (svc_reg)
      SVC_IDLE: begin
        if (wrap && irq_enabled) begin
          svc_next = SVC_PEND;
        end
      end
      SVC_PEND: begin
        if (irq_accept) begin
          svc_next = SVC_BUSY;
        end
      end
      SVC_BUSY: begin
        if (irq_return || irq_return_load_w) begin
          svc_next = (wrap && irq_enabled) ? SVC_PEND : SVC_IDLE;
        end
      end
      default: begin
        svc_next = SVC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      svc_reg <= SVC_IDLE;
      irq_request <= 1'b0;
      irq_in_service <= 1'b0;
      irq_vector <= IRQ_VECTOR;
    end else begin
      svc_reg <= svc_next;
      irq_request <= (svc_next == SVC_PEND);
      irq_in_service <= (svc_next == SVC_BUSY);
      irq_vector <= IRQ_VECTOR;
    end
  end

  // Checks
  a_pin_src_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    (source_select == SRC_PIN && prescaler_assign == PRE_TO_WATCHDOG && !counter_wr
     && instr_tick_reg && !event_seen_reg) |=> $stable(rt_event_counter))
    else $error("counter stepped with no pin event");

  a_edge_polarity: assert property (@(posedge clk_sys) disable iff (!resetn)
    (edge_polarity_sel == EDGE_FALL && $rose(pin_sync_reg) && !$past(event_seen_reg)
     && !instr_tick_reg) |=> !event_seen_reg || $fell(pin_sync_reg))
    else $error("rising edge taken in falling mode");

  a_wrap_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    wrap |=> rt_event_counter == CNT_WRAP)
    else $error("wrap did not give zero");

  a_no_irq_masked: assert property (@(posedge clk_sys) disable iff (!resetn)
    (svc_reg == SVC_IDLE && wrap && !irq_enabled) |=> !irq_request)
    else $error("interrupt raised while masked");

  a_irq_on_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
    (svc_reg == SVC_IDLE && wrap && irq_enabled) |=> irq_request [*1] ##0 svc_reg == SVC_PEND)
    else $error("wrap did not request interrupt");

  a_fuse_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    option_fuse_n |=> !w_alias_active)
    else $error("alias active with fuse set");

  a_sleep_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sleep_mode && $past(sleep_mode) && !counter_wr) |=> $stable(rt_event_counter))
    else $error("counter moved in sleep");

  a_write_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
    (counter_wr && prescaler_assign == PRE_TO_COUNTER) |=> pre_count == PRE_RESET)
    else $error("prescaler not cleared on write");

  a_pending_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wrap && HAS_PENDING_FLAG) |=> overflow_pending)
    else $error("pending flag missed a wrap");

  a_preload: assert property (@(posedge clk_sys) disable iff (!resetn)
    counter_wr |=> rt_event_counter == $past(counter_wdata))
    else $error("preload not stored");

  a_vector_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (irq_request && irq_accept) |=> irq_in_service && irq_vector == IRQ_VECTOR)
    else $error("accept did not enter service");

  a_instr_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    (source_select == SRC_INSTR && prescaler_assign == PRE_TO_WATCHDOG && !counter_wr
     && instr_tick_reg && !sleep_mode)
    |=> rt_event_counter == $past(rt_event_counter) + 8'h01)
    else $error("counter missed an instruction cycle");

  a_prescale_tap: assert property (@(posedge clk_sys) disable iff (!resetn)
    (prescaler_assign == PRE_TO_COUNTER && !counter_wr && count_event && !pre_count[0])
    |=> $stable(rt_event_counter))
    else $error("counter stepped before the prescaler tap");

  a_watchdog_owner: assert property (@(posedge clk_sys) disable iff (!resetn)
    (prescaler_assign == PRE_TO_COUNTER && !watchdog_rollover)
    |=> !watchdog_reset)
    else $error("watchdog pulse while prescaler serves the counter");

  a_irq_fuse: assert property (@(posedge clk_sys) disable iff (!resetn)
    (svc_reg == SVC_IDLE && option_fuse_n && wrap)
    |=> !irq_request)
    else $error("interrupt raised with option fuse set");

  c_wrap_irq: cover property (@(posedge clk_sys) disable iff (!resetn)
    wrap && irq_enabled);
  c_pin_count: cover property (@(posedge clk_sys) disable iff (!resetn)
    source_select == SRC_PIN && counter_step);
  c_div256: cover property (@(posedge clk_sys) disable iff (!resetn)
    divide_select == 3'h7 && prescaler_assign == PRE_TO_COUNTER && counter_step);
  c_svc_return: cover property (@(posedge clk_sys) disable iff (!resetn)
    irq_in_service ##1 !irq_in_service);
  c_watchdog_pulse: cover property (@(posedge clk_sys) disable iff (!resetn)
    prescaler_assign == PRE_TO_WATCHDOG && watchdog_reset);
endmodule

// >>> hdl/event_counter_value_pkg.sv
// Shared constants for the event counter block and its prescaler.
// Assumes one 25 MHz system clock and an active-low asynchronous reset.
package event_counter_pkg;
  // Counter and prescaler widths
  localparam int CNT_W = 8;
  localparam int PRE_W = 8;
  localparam int SEL_W = 3;
  // Reset, maximum and wrap values
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] PRE_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_WRAP = 8'h00;
  // Pending flag position in the timer-1 control B register
  localparam int PEND_BIT = 7;
  // Interrupt vector
  localparam logic [11:0] IRQ_VECTOR = 12'h000;
  // System clock cycles per instruction cycle
  localparam logic [3:0] INSTR_DIV_DEFAULT = 4'h4;
  // Clock source select codes
  localparam logic SRC_INSTR = 1'b0;
  localparam logic SRC_PIN = 1'b1;
  // Edge codes
  localparam logic EDGE_RISE = 1'b0;
  localparam logic EDGE_FALL = 1'b1;
  // Prescaler owner codes
  localparam logic PRE_TO_COUNTER = 1'b0;
  localparam logic PRE_TO_WATCHDOG = 1'b1;
  // Interrupt service states
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_PEND = 2'b01,
    SVC_BUSY = 2'b10
  } svc_state_t;
endpackage

// >>> hdl/shared_prescaler.sv
// Shared 8-bit prescaler with per-bit tap detection.
// Assumes advance and clear come from logic on the same clock.
`timescale 1ns/100ps
module shared_prescaler #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic clear,
  input wire logic advance,
  input wire logic [2:0] divide_select,
  // Results
  output logic [W-1:0] count_reg,
  output logic counter_carry,
  output logic watchdog_carry
);
  import event_counter_pkg::*;

  logic [W-1:0] low_ones;
  logic [W-1:0] count_next;

  // Low bits all ones means the selected bit is about to fall
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_ones
      assign low_ones[i] = &count_reg[i:0];
    end
  endgenerate

  assign count_next = count_reg + 1'b1;
  assign counter_carry = advance & low_ones[divide_select];
  assign watchdog_carry = advance &
    ((divide_select == 3'h0) ? 1'b1 : low_ones[divide_select - 3'h1]);

  // Clear beats advance, so a counter write starts a fresh division
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_reg <= PRE_RESET;
    end else if (clear) begin
      count_reg <= PRE_RESET;
    end else if (advance) begin
      count_reg <= count_next;
    end
  end
endmodule

// >>> tb/event_pin_source.sv
// Count-pin pulse source model: toggles the pin a requested number of times.
// Assumes requests arrive on clk_sys; the pin holds its last driven level.
`timescale 1ns/100ps
module event_pin_source (
  // Clock
  input wire logic clk_sys,
  // Request
  input wire logic start,
  input wire logic [7:0] toggles,
  input wire logic [7:0] spacing,
  // Pin and status
  output logic count_pin,
  output logic busy
);
  logic [7:0] left_reg;
  logic [7:0] gap_reg;
  initial begin
    count_pin = 1'b0;
    left_reg = 8'h00;
    gap_reg = 8'h00;
  end
  assign busy = (left_reg != 8'h00);
  // Spacing of one gives edges every clock, faster than the instruction tick
  always @(posedge clk_sys) begin
    if (left_reg == 8'h00) begin
      if (start) begin
        left_reg <= toggles;
      end
    end else if (gap_reg == 8'h00) begin
      count_pin <= ~count_pin;
      left_reg <= left_reg - 8'h01;
      gap_reg <= spacing - 8'h01;
    end else begin
      gap_reg <= gap_reg - 8'h01;
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the event counter, prescaler and overflow interrupt.
// Assumes the pin source model drives the count pin.
`timescale 1ns/100ps
module tb_top;
  import event_counter_pkg::*;
  localparam int ID = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic src, edg, asg, mask, asel, fuse_n, cwr, t1wr, wroll, wclr, slp, acc, ret, retw, go;
  logic pin, pbusy, pend, wrst, ireq, isvc, walias;
  logic [2:0] dsel;
  logic [7:0] cwd, t1wd, tgl, spc, cnt, v0;
  logic [11:0] ivec;
  int errors = 0;
  int samples_checked = 0;
  int n;
  always #20 clk = ~clk;
  realtime_counter_prescaler #(.INSTR_DIV(4'h4), .HAS_PENDING_FLAG(1'b1)) i_dut (
    .clk_sys(clk), .resetn(rstn), .count_pin(pin), .source_select(src),
    .edge_polarity_sel(edg), .prescaler_assign(asg), .divide_select(dsel),
    .overflow_irq_mask(mask), .w_alias_select(asel), .option_fuse_n(fuse_n),
    .counter_wr(cwr), .counter_wdata(cwd), .rt_event_counter(cnt),
    .timer1_control_b_wr(t1wr), .timer1_control_b_wdata(t1wd), .overflow_pending(pend),
    .watchdog_rollover(wroll), .watchdog_clear(wclr), .watchdog_reset(wrst),
    .sleep_mode(slp), .irq_accept(acc), .irq_return(ret), .irq_return_load_w(retw),
    .irq_request(ireq), .irq_in_service(isvc), .irq_vector(ivec), .w_alias_active(walias));
  event_pin_source i_src (.clk_sys(clk), .start(go), .toggles(tgl), .spacing(spc),
    .count_pin(pin), .busy(pbusy));
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Codes: 0 accept, 1 return, 2 return with W, 3 rollover, 4 clear, 5 pin run, 6 pend write
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: acc <= 1'b1;
      1: ret <= 1'b1;
      2: retw <= 1'b1;
      3: wroll <= 1'b1;
      4: wclr <= 1'b1;
      5: go <= 1'b1;
      default: t1wr <= 1'b1;
    endcase
    @(posedge clk);
    {acc, ret, retw, wroll, wclr, go, t1wr} <= '0;
    #1;
  endtask
  task automatic wr_cnt(input logic [7:0] d);
    @(posedge clk);
    cwr <= 1'b1;
    cwd <= d;
    @(posedge clk);
    cwr <= 1'b0;
    #1;
  endtask
  // Difference over a whole number of periods is exact whatever the tick phase
  task automatic rate(input int w, input logic [7:0] exp);
    #1;
    v0 = cnt;
    cyc(w);
    chkv(cnt - v0, exp);
  endtask
  task automatic pins(input logic [7:0] t, input logic [7:0] s, input logic e);
    @(posedge clk);
    tgl <= t;
    spc <= s;
    edg <= e;
    pulse(5);
    for (n = 0; n < 300 && pbusy !== 1'b0; n++) cyc(1);
    chkb(pbusy, 1'b0);
    if (pbusy !== 1'b0) summarize();
    cyc(4 * ID);
  endtask
  task automatic wait_irq();
    for (n = 0; n < 1200 && ireq !== 1'b1; n++) cyc(1);
    chkb(ireq, 1'b1);
    if (ireq !== 1'b1) summarize();
  endtask
  initial begin
    {src, edg, mask, asel, fuse_n, cwr, t1wr, wroll, wclr, slp, acc, ret, retw, go} = '0;
    asg = PRE_TO_WATCHDOG;
    dsel = 3'h7;
    cwd = 8'h00;
    t1wd = 8'h00;
    tgl = 8'h00;
    spc = 8'h01;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    chkv(cnt, CNT_RESET);
    chkb(ireq, 1'b0);
    chkb(ivec === IRQ_VECTOR, 1'b1);
    wr_cnt(8'h9c);
    chkv(cnt, 8'h9c);
    rate(10 * ID, 8'd10);
    @(posedge clk);
    asg <= PRE_TO_COUNTER;
    for (int d = 0; d < 8; d++) begin
      @(posedge clk);
      dsel <= d[2:0];
      rate((4 * ID) << d, 8'd2);
    end
    v0 = cnt;
    for (n = 0; n < 1100 && cnt === v0; n++) cyc(1);
    chkb(cnt !== v0, 1'b1);
    if (cnt === v0) summarize();
    cyc(150 * ID);
    wr_cnt(8'h00);
    cyc(250 * ID);
    chkv(cnt, 8'h00);
    @(posedge clk);
    asg <= PRE_TO_WATCHDOG;
    slp <= 1'b1;
    rate(10 * ID, 8'd0);
    @(posedge clk);
    slp <= 1'b0;
    src <= SRC_PIN;
    wr_cnt(8'h00);
    pins(8'd9, 8'd8, EDGE_RISE);
    chkv(cnt, 8'd5);
    pins(8'd1, 8'd8, EDGE_FALL);
    wr_cnt(8'h00);
    pins(8'd9, 8'd8, EDGE_FALL);
    chkv(cnt, 8'd4);
    pins(8'd1, 8'd8, EDGE_RISE);
    wr_cnt(8'h00);
    pins(8'd8, 8'd1, EDGE_RISE);
    chkb(cnt >= 8'd2 && cnt <= 8'd3, 1'b1);
    for (int a = 1; a >= 0; a--) begin
      @(posedge clk);
      asg <= a[0];
      dsel <= 3'h1;
      pulse(4);
      n = 0;
      for (int k = 0; k < 4; k++) begin
        pulse(3);
        repeat (3) begin
          n += int'(wrst === 1'b1);
          cyc(1);
        end
      end
      chkv(n[7:0], (a == 1) ? 8'd2 : 8'd4);
    end
    @(posedge clk);
    src <= SRC_INSTR;
    asg <= PRE_TO_WATCHDOG;
    asel <= 1'b1;
    wr_cnt(8'hfd);
    wait_irq();
    chkv(cnt, CNT_WRAP);
    chkb(pend, 1'b1);
    chkb(walias, 1'b1);
    pulse(0);
    chkb(ireq, 1'b0);
    chkb(isvc, 1'b1);
    pulse(1);
    chkb(isvc, 1'b0);
    pulse(6);
    chkb(pend, 1'b0);
    wr_cnt(8'hfd);
    wait_irq();
    pulse(0);
    pulse(2);
    chkb(isvc, 1'b0);
    @(posedge clk);
    mask <= 1'b1;
    pulse(6);
    chkb(pend, 1'b0);
    wr_cnt(8'hfd);
    cyc(8 * ID);
    chkb(ireq, 1'b0);
    chkb(pend, 1'b1);
    @(posedge clk);
    mask <= 1'b0;
    fuse_n <= 1'b1;
    wr_cnt(8'hfd);
    cyc(8 * ID);
    chkb(ireq, 1'b0);
    chkb(walias, 1'b0);
    summarize();
  end
endmodule
